// file: logic/adc_ctrl_pkg.sv
// Constants, field layouts and types for the input coding and sequence loader
package adc_ctrl_pkg;

   // Serial word layout
   localparam int WORD_BITS = 16;
   localparam int SEL_MSB = 15;
   localparam int SEL_LSB = 11;
   localparam int FIELD_MSB = 10;
   localparam int FIELD_LSB = 3;
   localparam int COM_BIT = 2;
   localparam int MODE_FLAG_BIT = 15;
   localparam int MODE_MSB = 14;
   localparam int MODE_LSB = 11;
   localparam int CHSEL_MSB = 10;
   localparam int CHSEL_LSB = 7;
   localparam int SHDN_BIT = 3;

   // Register select codes in bits 15:11
   localparam logic [4:0] SEL_UNIPOLAR = 5'h11;
   localparam logic [4:0] SEL_BIPOLAR = 5'h12;
   localparam logic [4:0] SEL_SPAN = 5'h13;
   localparam logic [4:0] SEL_SCAN_HI = 5'h14;
   localparam logic [4:0] SEL_SCAN_LO = 5'h15;
   localparam logic [4:0] SEL_SEQUENCE = 5'h16;

   // Scan mode codes in the mode control word
   localparam logic [3:0] MODE_MANUAL = 4'h0;
   localparam logic [3:0] MODE_REPEAT = 4'h1;
   localparam logic [3:0] MODE_STD_INT = 4'h2;
   localparam logic [3:0] MODE_STD_EXT = 4'h3;
   localparam logic [3:0] MODE_UPPER_INT = 4'h4;
   localparam logic [3:0] MODE_UPPER_SCAN_EXT_CLK = 4'h5;
   localparam logic [3:0] MODE_CUSTOM_INT = 4'h6;
   localparam logic [3:0] MODE_CUSTOM_SCAN_EXT_CLK = 4'h7;
   localparam logic [3:0] MODE_SEQUENCE = 4'h8;

   // Sequence storage
   localparam int SEQ_DEPTH = 256;
   localparam int NIBBLE_BITS = 4;

   // Values after reset, and last counts of the bit and nibble counters
   localparam logic [7:0] PAIR_FIELD_RESET = 8'h00;
   localparam logic [15:0] SCAN_RESET = 16'h0000;
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [3:0] CHAN_RESET = 4'h0;
   localparam logic [7:0] LEN_RESET = 8'h00;
   localparam logic [3:0] BITCNT_LAST = 4'hf;
   localparam logic [1:0] NIBCNT_LAST = 2'h3;

   typedef struct packed {
      logic twos_comp;
      logic differential;
      logic common_ref;
      logic full_span;
   } coding_t;

   localparam coding_t CODING_RESET = '0;

   typedef enum logic [1:0] {LS_CMD, LS_ARMED, LS_PATTERN} link_state_t;

endpackage

// file: logic/pin_sync.sv
// Two-stage synchroniser for one pin
`timescale 1ns/1ps
module pin_sync #(
   parameter logic IDLE = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pin,
   output logic pin_s
);
   logic meta_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_ff <= IDLE;
         pin_s <= IDLE;
      end else begin
         meta_ff <= pin;
         pin_s <= meta_ff;
      end
   end
endmodule

// file: logic/pair_coding_decode.sv
// Input configuration and output coding of one channel
`timescale 1ns/1ps
module pair_coding_decode (
   input wire logic [3:0] channel,
   input wire logic [7:0] unipolar_bits,
   input wire logic [7:0] bipolar_bits,
   input wire logic [7:0] span_bits,
   input wire logic common_reference_enable,
   output adc_ctrl_pkg::coding_t coding
);
   // Pair 0 sits in the top bit of each field
   wire logic [2:0] pair_idx = 3'h7 - channel[3:1];
   wire logic uni_bit = unipolar_bits[pair_idx];
   wire logic bip_bit = bipolar_bits[pair_idx];
   wire logic span_bit = span_bits[pair_idx];

   always_comb begin
      coding = adc_ctrl_pkg::CODING_RESET;
      if (common_reference_enable) begin
         coding.common_ref = 1'b1;
      end else if (uni_bit) begin
         coding.differential = 1'b1;
      end else if (bip_bit) begin
         coding.differential = 1'b1;
         coding.twos_comp = 1'b1;
         coding.full_span = span_bit;
      end
      // Otherwise single-ended straight binary
   end
endmodule

// file: logic/adc_input_coding_and_sequence_loader.sv
`timescale 1ns/1ps
module adc_input_coding_and_sequence_loader (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   output logic [3:0] active_channel_ff,
   output logic [15:0] channel_mask_ff,
   output adc_ctrl_pkg::coding_t coding_ff,
   output logic [3:0] scan_mode_ff,
   output logic seq_running_ff,
   output logic [7:0] seq_index_ff,
   output logic [7:0] seq_last_ff,
   output logic shutdown_ff
);
   // Pin synchronisers
   logic cs_n_s;
   logic sclk_s;
   logic din_s;
   logic cs_d_ff;
   logic sclk_d_ff;

   // Chip select idles high, so no false edge follows reset
   pin_sync #(
      .IDLE(1'b1)
   ) u_sync_cs (
      .core_clk(core_clk),
      .rst(rst),
      .pin(cs_n),
      .pin_s(cs_n_s)
   );
   pin_sync u_sync_sclk (
      .core_clk(core_clk),
      .rst(rst),
      .pin(sclk),
      .pin_s(sclk_s)
   );
   pin_sync u_sync_din (
      .core_clk(core_clk),
      .rst(rst),
      .pin(din),
      .pin_s(din_s)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cs_d_ff <= 1'b1;
         sclk_d_ff <= 1'b0;
      end else begin
         cs_d_ff <= cs_n_s;
         sclk_d_ff <= sclk_s;
      end
   end

   wire logic cs_fall = cs_d_ff & ~cs_n_s;
   wire logic cs_rise = ~cs_d_ff & cs_n_s;
   wire logic bit_taken = sclk_s & ~sclk_d_ff & ~cs_n_s;

   // Link state and word assembly
   adc_ctrl_pkg::link_state_t state_ff;
   adc_ctrl_pkg::link_state_t nxt_state;
   logic [15:0] shift_ff;
   logic [3:0] bit_cnt_ff;
   logic [1:0] nib_cnt_ff;
   logic [2:0] nib_sh_ff;
   logic [8:0] wr_idx_ff;
   logic [7:0] load_len_ff;
   logic pattern_new_ff;

   wire logic [15:0] word = {shift_ff[14:0], din_s};
   wire logic word_done = (state_ff == adc_ctrl_pkg::LS_CMD) & bit_taken &
      (bit_cnt_ff == adc_ctrl_pkg::BITCNT_LAST);
   wire logic [4:0] sel_code = word[adc_ctrl_pkg::SEL_MSB:adc_ctrl_pkg::SEL_LSB];
   wire logic [7:0] field = word[adc_ctrl_pkg::FIELD_MSB:adc_ctrl_pkg::FIELD_LSB];
   wire logic is_mode_wr = word_done & ~word[adc_ctrl_pkg::MODE_FLAG_BIT];
   wire logic span_wr = word_done & (sel_code == adc_ctrl_pkg::SEL_SPAN);
   wire logic uni_wr = word_done & (sel_code == adc_ctrl_pkg::SEL_UNIPOLAR);
   wire logic bip_wr = word_done & (sel_code == adc_ctrl_pkg::SEL_BIPOLAR);
   wire logic scan_hi_wr = word_done & (sel_code == adc_ctrl_pkg::SEL_SCAN_HI);
   wire logic scan_lo_wr = word_done & (sel_code == adc_ctrl_pkg::SEL_SCAN_LO);
   wire logic len_wr = word_done & (sel_code == adc_ctrl_pkg::SEL_SEQUENCE);
   wire logic pat_start = (state_ff == adc_ctrl_pkg::LS_ARMED) & cs_fall;
   wire logic nib_done = (state_ff == adc_ctrl_pkg::LS_PATTERN) & bit_taken &
      (nib_cnt_ff == adc_ctrl_pkg::NIBCNT_LAST);
   wire logic [3:0] nib_val = {nib_sh_ff, din_s};
   // Entries past the programmed length are dropped
   wire logic nib_keep = nib_done & (wr_idx_ff <= {1'b0, load_len_ff});

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         adc_ctrl_pkg::LS_CMD: begin
            if (len_wr) begin
               nxt_state = adc_ctrl_pkg::LS_ARMED;
            end
         end
         adc_ctrl_pkg::LS_ARMED: begin
            if (cs_fall) begin
               nxt_state = adc_ctrl_pkg::LS_PATTERN;
            end
         end
         adc_ctrl_pkg::LS_PATTERN: begin
            if (cs_rise) begin
               nxt_state = adc_ctrl_pkg::LS_CMD;
            end
         end
         default: nxt_state = adc_ctrl_pkg::LS_CMD;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff <= adc_ctrl_pkg::LS_CMD;
         shift_ff <= '0;
         bit_cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         if (cs_fall) begin
            bit_cnt_ff <= '0;
         end else if (bit_taken) begin
            shift_ff <= word;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
      end
   end

   // Pattern frame capture
   always_ff @(posedge core_clk) begin
      if (rst) begin
         nib_cnt_ff <= '0;
         nib_sh_ff <= '0;
         wr_idx_ff <= '0;
         load_len_ff <= adc_ctrl_pkg::LEN_RESET;
      end else begin
         if (len_wr) begin
            load_len_ff <= field;
         end
         if (pat_start) begin
            nib_cnt_ff <= '0;
            wr_idx_ff <= '0;
         end else if (bit_taken && state_ff == adc_ctrl_pkg::LS_PATTERN) begin
            nib_cnt_ff <= nib_cnt_ff + 2'h1;
            nib_sh_ff <= nib_val[2:0];
            if (nib_done && !wr_idx_ff[8]) begin
               wr_idx_ff <= wr_idx_ff + 9'h001;
            end
         end
      end
   end

   // Sequence storage, cleared when the pattern frame opens
   logic [3:0] seq_mem_ff [0:adc_ctrl_pkg::SEQ_DEPTH-1];

   always_ff @(posedge core_clk) begin
      if (rst || pat_start) begin
         for (int i = 0; i < adc_ctrl_pkg::SEQ_DEPTH; i++) begin
            seq_mem_ff[i] <= adc_ctrl_pkg::CHAN_RESET;
         end
      end else if (nib_keep) begin
         seq_mem_ff[wr_idx_ff[7:0]] <= nib_val;
      end
   end

   // Configuration registers
   logic [7:0] span_ff;
   logic [7:0] uni_ff;
   logic [7:0] bip_ff;
   logic com_ff;
   logic [15:0] scan_en_ff;
   logic [3:0] chsel_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         span_ff <= adc_ctrl_pkg::PAIR_FIELD_RESET;
         uni_ff <= adc_ctrl_pkg::PAIR_FIELD_RESET;
         bip_ff <= adc_ctrl_pkg::PAIR_FIELD_RESET;
         com_ff <= 1'b0;
         scan_en_ff <= adc_ctrl_pkg::SCAN_RESET;
         scan_mode_ff <= adc_ctrl_pkg::MODE_RESET;
         chsel_ff <= adc_ctrl_pkg::CHAN_RESET;
      end else begin
         if (span_wr) begin
            span_ff <= field;
         end
         if (uni_wr) begin
            uni_ff <= field;
            com_ff <= word[adc_ctrl_pkg::COM_BIT];
         end
         if (bip_wr) begin
            bip_ff <= field;
         end
         if (scan_hi_wr) begin
            scan_en_ff[15:8] <= field;
         end
         if (scan_lo_wr) begin
            scan_en_ff[7:0] <= field;
         end
         if (is_mode_wr) begin
            scan_mode_ff <= word[adc_ctrl_pkg::MODE_MSB:adc_ctrl_pkg::MODE_LSB];
            chsel_ff <= word[adc_ctrl_pkg::CHSEL_MSB:adc_ctrl_pkg::CHSEL_LSB];
         end
      end
   end

   // Sequence playback
   logic frame_in_run_ff;
   wire logic seq_start = is_mode_wr &
      (word[adc_ctrl_pkg::MODE_MSB:adc_ctrl_pkg::MODE_LSB] == adc_ctrl_pkg::MODE_SEQUENCE);
   wire logic last_readout = frame_in_run_ff & seq_running_ff & (seq_index_ff == seq_last_ff);
   wire logic shdn_req = is_mode_wr & word[adc_ctrl_pkg::SHDN_BIT];
   wire logic shdn_ok = shdn_req & (last_readout | ~seq_running_ff);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pattern_new_ff <= 1'b0;
         seq_last_ff <= adc_ctrl_pkg::LEN_RESET;
         seq_running_ff <= 1'b0;
         seq_index_ff <= '0;
         frame_in_run_ff <= 1'b0;
         shutdown_ff <= 1'b0;
      end else begin
         if (state_ff == adc_ctrl_pkg::LS_PATTERN && cs_rise) begin
            pattern_new_ff <= 1'b1;
         end else if (cs_fall && pattern_new_ff) begin
            pattern_new_ff <= 1'b0;
            seq_last_ff <= load_len_ff;
         end
         if (cs_fall) begin
            frame_in_run_ff <= seq_running_ff;
         end
         if (seq_start) begin
            seq_running_ff <= 1'b1;
            seq_index_ff <= '0;
            frame_in_run_ff <= 1'b0;
         end else if (cs_rise && frame_in_run_ff && seq_running_ff) begin
            if (seq_index_ff == seq_last_ff) begin
               seq_running_ff <= 1'b0;
            end else begin
               seq_index_ff <= seq_index_ff + 8'h01;
            end
         end
         if (shdn_ok) begin
            shutdown_ff <= 1'b1;
         end else if (is_mode_wr && !shdn_req) begin
            shutdown_ff <= 1'b0;
         end
      end
   end

   // Channel selection by mode
   logic [3:0] first_scan;
   logic [3:0] nxt_channel;
   logic [15:0] nxt_mask;
   wire logic custom_mode = (scan_mode_ff == adc_ctrl_pkg::MODE_CUSTOM_INT) |
      (scan_mode_ff == adc_ctrl_pkg::MODE_CUSTOM_SCAN_EXT_CLK);
   wire logic seq_mode = (scan_mode_ff == adc_ctrl_pkg::MODE_SEQUENCE);
   wire logic [3:0] seq_chan = seq_mem_ff[seq_index_ff];

   always_comb begin
      first_scan = adc_ctrl_pkg::CHAN_RESET;
      for (int i = 15; i >= 0; i--) begin
         if (scan_en_ff[i]) begin
            first_scan = 4'(i);
         end
      end
   end

   always_comb begin
      nxt_channel = chsel_ff;
      nxt_mask = 16'h0001 << chsel_ff;
      if (custom_mode) begin
         nxt_channel = first_scan;
         nxt_mask = scan_en_ff;
      end else if (seq_mode) begin
         nxt_channel = seq_chan;
         nxt_mask = 16'h0001 << seq_chan;
      end
   end

   adc_ctrl_pkg::coding_t nxt_coding;

   pair_coding_decode u_decode (
      .channel(nxt_channel),
      .unipolar_bits(uni_ff),
      .bipolar_bits(bip_ff),
      .span_bits(span_ff),
      .common_reference_enable(com_ff),
      .coding(nxt_coding)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         active_channel_ff <= adc_ctrl_pkg::CHAN_RESET;
         channel_mask_ff <= adc_ctrl_pkg::SCAN_RESET;
         coding_ff <= adc_ctrl_pkg::CODING_RESET;
      end else begin
         active_channel_ff <= nxt_channel;
         channel_mask_ff <= nxt_mask;
         coding_ff <= nxt_coding;
      end
   end
endmodule

// file: dv/adc_loader_checker.sv
// Port-level assertions for the input coding and sequence loader
`timescale 1ns/1ps
module adc_loader_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic [3:0] active_channel_ff,
   input wire logic [15:0] channel_mask_ff,
   input wire adc_ctrl_pkg::coding_t coding_ff,
   input wire logic [3:0] scan_mode_ff,
   input wire logic seq_running_ff,
   input wire logic [7:0] seq_index_ff,
   input wire logic [7:0] seq_last_ff,
   input wire logic shutdown_ff
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic custom = scan_mode_ff == adc_ctrl_pkg::MODE_CUSTOM_INT ||
      scan_mode_ff == adc_ctrl_pkg::MODE_CUSTOM_SCAN_EXT_CLK;
   one_hot_a:
      assert property (!$past(rst) && $stable(scan_mode_ff) && $stable(active_channel_ff) &&
         $stable(channel_mask_ff) && scan_mode_ff < 4'h6 |->
         channel_mask_ff == 16'h0001 << active_channel_ff)
      else $error("mask is not the selected channel");
   scan_low_a:
      assert property ($stable(scan_mode_ff) && $stable(active_channel_ff) &&
         $stable(channel_mask_ff) && custom && channel_mask_ff != 16'h0000 |->
         channel_mask_ff[active_channel_ff] &&
         (channel_mask_ff & ((16'h0001 << active_channel_ff) - 16'h0001)) == 16'h0000)
      else $error("custom channel not lowest enable");
   span_bip_a:
      assert property (coding_ff.full_span |-> coding_ff.twos_comp)
      else $error("span applied off bipolar pair");
   com_bin_a:
      assert property (coding_ff.common_ref |-> !coding_ff.twos_comp && !coding_ff.differential)
      else $error("common reference not binary");
   twos_diff_a:
      assert property (coding_ff.twos_comp |-> coding_ff.differential)
      else $error("twos complement on single input");
   seq_start_a:
      assert property ($rose(seq_running_ff) |-> seq_index_ff == 8'h00)
      else $error("playback not from first entry");
   seq_step_a:
      assert property (seq_running_ff && $past(seq_running_ff) && $changed(seq_index_ff) |->
         seq_index_ff == $past(seq_index_ff) + 8'h01)
      else $error("index skipped an entry");
   seq_bound_a:
      assert property (seq_running_ff |-> seq_index_ff <= seq_last_ff)
      else $error("index past last entry");
   shut_last_a:
      assert property ($rose(shutdown_ff) && $past(seq_running_ff) |->
         $past(seq_index_ff) == $past(seq_last_ff))
      else $error("shutdown taken before last entry");
endmodule

bind adc_input_coding_and_sequence_loader adc_loader_checker chk_i (.core_clk(core_clk),
   .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din), .active_channel_ff(active_channel_ff),
   .channel_mask_ff(channel_mask_ff), .coding_ff(coding_ff), .scan_mode_ff(scan_mode_ff),
   .seq_running_ff(seq_running_ff), .seq_index_ff(seq_index_ff),
   .seq_last_ff(seq_last_ff), .shutdown_ff(shutdown_ff));

// file: dv/host_link_model.sv
// Host model driving the serial link frames
`timescale 1ns/1ps
module host_link_model (
   input wire logic core_clk,
   output logic cs_n,
   output logic sclk,
   output logic din
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   // Chip select falls, clock idles low
   task automatic open_frame();
      repeat (8) @(posedge core_clk);
      cs_n <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask
   // One bit, set while clock low, taken on its rise
   task automatic shift_bit(input logic b);
      din <= b;
      repeat (4) @(posedge core_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      sclk <= 1'b0;
   endtask
   task automatic send_word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         shift_bit(w[i]);
      end
   endtask
   task automatic send_nib(input logic [3:0] n);
      for (int i = 3; i >= 0; i--) begin
         shift_bit(n[i]);
      end
   endtask
   // Released data line shows the inverse of its last value
   task automatic close_frame();
      repeat (4) @(posedge core_clk);
      cs_n <= 1'b1;
      din <= ~din;
      repeat (8) @(posedge core_clk);
   endtask
endmodule

// file: dv/adc_input_coding_and_sequence_loader_bench.sv
// Self-checking bench for the input coding and sequence loader
`timescale 1ns/1ps
module adc_input_coding_and_sequence_loader_bench;
   logic core_clk;
   logic rst;
   logic cs_n;
   logic sclk;
   logic din;
   logic [3:0] chan;
   logic [15:0] mask;
   adc_ctrl_pkg::coding_t coding;
   logic [3:0] mode;
   logic run;
   logic [7:0] idx;
   logic [7:0] last;
   logic shdn;
   int failures;
   int n_tests;
   adc_input_coding_and_sequence_loader uut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
      .sclk(sclk), .din(din), .active_channel_ff(chan), .channel_mask_ff(mask),
      .coding_ff(coding), .scan_mode_ff(mode), .seq_running_ff(run), .seq_index_ff(idx),
      .seq_last_ff(last), .shutdown_ff(shdn));
   host_link_model host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .din(din));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] w);
      host.open_frame();
      host.send_word(w);
      host.close_frame();
   endtask
   function automatic logic [15:0] mw(input logic [3:0] m, input logic [3:0] c, input logic s);
      return {1'b0, m, c, 3'b000, s, 3'b000};
   endfunction
   task automatic t_coding();
      logic u, b, pc, sp;
      logic [7:0] one;
      logic [3:0] c;
      for (int p = 0; p < 8; p++) begin
         for (int k = 0; k < 5; k++) begin
            one = 8'h80 >> p;
            {u, pc, b} = (k == 4) ? 3'b111 : {k[1], 1'b0, k[0]};
            sp = p[0];
            c = 4'(2 * p + k % 2);
            wr({adc_ctrl_pkg::SEL_UNIPOLAR, u ? one : ~one, pc, 2'b00});
            wr({adc_ctrl_pkg::SEL_BIPOLAR, b ? one : ~one, 3'b000});
            if (p > 0) wr({adc_ctrl_pkg::SEL_SPAN, sp ? one : ~one, 3'b111});
            wr(mw(adc_ctrl_pkg::MODE_MANUAL, c, 1'b0));
            chk(16'(coding), {12'h000, b & !u & !pc, (u | b) & !pc, pc, sp & b & !u & !pc});
            chk(16'(chan), 16'(c));
            chk(mask, 16'h0001 << c);
         end
      end
   endtask
   task automatic t_modes();
      wr({adc_ctrl_pkg::SEL_SCAN_HI, 8'h0a, 3'b000});
      wr({adc_ctrl_pkg::SEL_SCAN_LO, 8'h50, 3'b000});
      for (int m = 0; m < 8; m++) begin
         wr(mw(4'(m), 4'h3, 1'b0));
         chk(16'(mode), 16'(m));
         chk(mask, m > 5 ? 16'h0a50 : 16'h0008);
         chk(16'(chan), m > 5 ? 16'h0004 : 16'h0003);
      end
      wr(16'hf8ff);
      chk(mask, 16'h0a50);
   endtask
   task automatic t_seq();
      logic [3:0] e[4] = '{4'h5, 4'h9, 4'h0, 4'h0};
      wr({adc_ctrl_pkg::SEL_SEQUENCE, 8'h03, 3'b000});
      host.open_frame();
      for (int i = 0; i < 2; i++) begin
         host.send_nib(e[i]);
      end
      for (int i = 0; i < 2; i++) begin
         host.shift_bit(e[0][i]);
      end
      host.close_frame();
      wr(mw(adc_ctrl_pkg::MODE_SEQUENCE, 4'h0, 1'b0));
      chk(16'(last), 16'h0003);
      for (int i = 0; i < 4; i++) begin
         chk(16'(run), 16'h0001);
         chk(16'(idx), 16'(i));
         chk(16'(chan), 16'(e[i]));
         chk(16'(shdn), 16'h0000);
         wr(i == 3 ? mw(adc_ctrl_pkg::MODE_MANUAL, 4'h0, 1'b1) : 16'hf800);
      end
      chk(16'(shdn), 16'h0001);
      chk(16'(run), 16'h0000);
   endtask
   task automatic t_surplus();
      logic [3:0] pat[4] = '{4'h3, 4'h4, 4'h7, 4'h7};
      wr({adc_ctrl_pkg::SEL_SEQUENCE, 8'h01, 3'b000});
      host.open_frame();
      for (int i = 0; i < 4; i++) begin
         host.send_nib(pat[i]);
      end
      host.close_frame();
      wr(mw(adc_ctrl_pkg::MODE_SEQUENCE, 4'h0, 1'b0));
      chk(16'(last), 16'h0001);
      chk(16'(shdn), 16'h0000);
      chk(16'(chan), 16'h0003);
      wr(16'hf800);
      chk(16'(chan), 16'h0004);
      wr(16'hf800);
      chk(16'(run), 16'h0000);
   endtask
   // Reset after playback has stopped brings last index, coding and run flag back to their reset values and the mask to channel 0
   task automatic t_reset();
      rst <= 1'b1;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(16'(last), 16'h0000);
      chk(mask, 16'h0001);
      chk(16'(coding), 16'h0000);
      chk(16'(run), 16'h0000);
   endtask
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      failures = 0;
      n_tests = 0;
      rst = 1'b1;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(mask, 16'h0001);
      chk(16'(coding), 16'h0000);
      t_coding();
      t_modes();
      t_seq();
      t_surplus();
      t_reset();
      print_verdict();
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      failures++;
      print_verdict();
   end
endmodule
